// File: rtl/sci_pkg.sv
// Constants and types shared by the sensor command interface.
// Assumes a single system clock; all pins are synchronised inside the block.
package sci_pkg;
    // Upper nibble of the first command byte
    localparam logic [3:0] OP_BURST  = 4'h1;
    localparam logic [3:0] OP_WATCH  = 4'h2;
    localparam logic [3:0] OP_SINGLE = 4'h3;
    localparam logic [3:0] OP_FETCH  = 4'h4;
    localparam logic [3:0] OP_RREAD  = 4'h5;
    localparam logic [3:0] OP_RWRITE = 4'h6;
    localparam logic [3:0] OP_LEAVE  = 4'h8;
    localparam logic [3:0] OP_RECALL = 4'hD;
    localparam logic [3:0] OP_STORE  = 4'hE;
    localparam logic [3:0] OP_RESET  = 4'hF;
    // Full single-byte commands
    localparam logic [7:0] CMD_LEAVE  = 8'h80;
    localparam logic [7:0] CMD_RECALL = 8'hD0;
    localparam logic [7:0] CMD_STORE  = 8'hE0;
    localparam logic [7:0] CMD_RESET  = 8'hF0;
    // Command lengths in bytes
    localparam logic [2:0] LEN_ONE    = 3'h1;
    localparam logic [2:0] LEN_RREAD  = 3'h2;
    localparam logic [2:0] LEN_RWRITE = 3'h4;
    // Interface lock field: upper bit forces, lower bit picks the bus
    localparam int LOCK_FORCE = 1;
    localparam int LOCK_I2C   = 0;
    // Mode masks in status order burst, watch, single
    localparam logic [2:0] MODE_BURST  = 3'h4;
    localparam logic [2:0] MODE_WATCH  = 3'h2;
    localparam logic [2:0] MODE_SINGLE = 3'h1;
    localparam logic [6:0] I2C_ADDR_DEF = 7'h0C;
    // Response: status byte plus up to four words
    localparam int RSP_W = 72;

    // Two-wire slave states
    typedef enum logic [6:0] {
        I2_IDLE  = 7'h01,
        I2_ADDR  = 7'h02,
        I2_AACK  = 7'h04,
        I2_WBYTE = 7'h08,
        I2_WACK  = 7'h10,
        I2_RBYTE = 7'h20,
        I2_RACK  = 7'h40
    } sci_i2c_t;

    // Whole register state of the interpreter
    typedef struct packed {
        logic [1:0]       cs_s;
        logic [1:0]       sck_s;
        logic [1:0]       sdi_s;
        logic [1:0]       scl_s;
        logic [1:0]       sda_s;
        logic [1:0]       trg_s;
        logic             cs_p;
        logic             sck_p;
        logic             scl_p;
        logic             sda_p;
        logic             trg_p;
        logic [7:0]       ssh;
        logic [2:0]       sbit;
        logic             sdo;
        logic             sresp;
        sci_i2c_t         ist;
        logic [7:0]       ish;
        logic [3:0]       ibit;
        logic             irw;
        logic             sda_drv;
        logic [7:0]       op;
        logic [23:0]      args;
        logic [2:0]       nbyte;
        logic             done;
        logic             lk_set;
        logic             lk_i2c;
        logic [RSP_W-1:0] rsp;
        logic             fresh;
        logic             pend;
        logic             burst;
        logic             watch;
        logic             single;
        logic             rs;
        logic [3:0]       axis;
        logic             start;
        logic             leave;
        logic             recall;
        logic             store;
        logic             srst;
        logic             taken;
        logic             re;
        logic             we;
        logic [5:0]       addr;
        logic [15:0]      wdata;
    } sci_state_t;
endpackage

// File: rtl/sci_cmd_if.sv
// Command interpreter of a three-axis field sensor: SPI and two-wire slave.
// Assumes measurement engine, register file and nonvolatile memory outside.
//
// Contract
// - Chip select low is SPI, high is two-wire.
// - First complete command other than reset (F0), even a rejected one, locks bus unless forced.
// - Every command but reset yields status.
// - Two-wire acknowledges every command byte.
// - Decode ten command opcodes from first byte.
// - Nibble picks axes; zero uses default.
// - Status byte first, fixed bit layout.
// - Rejected mode command clears its mode bit.
// - Single flag from command or trigger pin.
// - Double fault: error, reject all but reset.
// - Reading results while not ready flags error.
// - Reset-seen set after reset, cleared once read.
// - Length code gives two times plus two.
// - Half-duplex SPI up to ten megahertz.
// - SPI mode three, select active low.
// - Bytes and words sent most significant first.
// - Mode, exit, recall, store: status only.
// - Reset command warm-resets, next status shows it.
// - Results in order T, X, Y, Z, skipping.
`timescale 1ns/10ps
module sci_cmd_if #(
    parameter logic [6:0] P_I2C_ADDR = sci_pkg::I2C_ADDR_DEF
) (
    input  wire logic        i_clk,
    input  wire logic        i_sys_rst,
    input  wire logic        i_protocol_select_n,
    input  wire logic        i_sck,
    input  wire logic        i_sdi,
    output logic             o_sdo,
    output logic             o_sdo_oe_n,
    input  wire logic        i_scl,
    input  wire logic        i_sda,
    output logic             o_sda_o,
    output logic             o_sda_oe_n,
    input  wire logic [1:0]  i_interface_lock_field,
    input  wire logic [3:0]  i_burst_sel,
    input  wire logic        i_trigger_pin,
    input  wire logic        i_trig_en,
    input  wire logic        i_single_done,
    input  wire logic        i_result_ready_flag,
    input  wire logic        i_ecc_double,
    input  wire logic        i_corrected_bit_flag,
    input  wire logic [15:0] i_meas_t,
    input  wire logic [15:0] i_meas_x,
    input  wire logic [15:0] i_meas_y,
    input  wire logic [15:0] i_meas_z,
    input  wire logic [15:0] i_reg_rdata,
    output logic             o_burst_active,
    output logic             o_change_watch_active_flag,
    output logic             o_single_active_flag,
    output logic             o_reset_seen_flag,
    output logic [3:0]       o_axis_sel,
    output logic             o_start,
    output logic             o_leave,
    output logic             o_nv_recall,
    output logic             o_nv_store,
    output logic             o_soft_reset,
    output logic             o_results_taken,
    output logic             o_reg_re,
    output logic             o_reg_we,
    output logic [5:0]       o_reg_addr,
    output logic [15:0]      o_reg_wdata
);
    sci_pkg::sci_state_t r;
    sci_pkg::sci_state_t n;

    logic        cs;
    logic        spi_ok;
    logic        i2c_ok;
    logic        bv;
    logic        bi2c;
    logic [7:0]  bdat;
    logic        tx_sh;
    logic        exec;
    logic [7:0]  first;
    logic [23:0] argv;
    logic [2:0]  need;
    logic [3:0]  sel;
    logic        rej;
    logic        ferr;
    logic        rt;
    logic [2:0]  expm;
    logic [2:0]  modes;
    logic [1:0]  dlen;
    logic [2:0]  k;
    logic [63:0] dat;
    logic [63:0] mv;
    logic        busy;

    // Next-state logic for both slaves and the interpreter
    always_comb begin
        n     = r;
        bv    = 1'b0;
        bi2c  = 1'b0;
        bdat  = 8'h00;
        tx_sh = 1'b0;
        exec  = 1'b0;
        rej   = 1'b0;
        ferr  = 1'b0;
        rt    = 1'b0;
        expm  = 3'h0;
        dlen  = 2'h0;
        k     = 3'h0;
        dat   = 64'h0;
        mv    = {i_meas_z, i_meas_y, i_meas_x, i_meas_t};
        busy  = r.burst | r.watch;
        cs    = r.cs_s[1];
        // Pulses last one cycle
        n.start  = 1'b0;
        n.leave  = 1'b0;
        n.recall = 1'b0;
        n.store  = 1'b0;
        n.srst   = 1'b0;
        n.taken  = 1'b0;
        n.re     = 1'b0;
        n.we     = 1'b0;
        // Pin synchronisers, second stage feeds the edge history
        n.cs_s  = {r.cs_s[0], i_protocol_select_n};
        n.sck_s = {r.sck_s[0], i_sck};
        n.sdi_s = {r.sdi_s[0], i_sdi};
        n.scl_s = {r.scl_s[0], i_scl};
        n.sda_s = {r.sda_s[0], i_sda};
        n.trg_s = {r.trg_s[0], i_trigger_pin};
        n.cs_p  = r.cs_s[1];
        n.sck_p = r.sck_s[1];
        n.scl_p = r.scl_s[1];
        n.sda_p = r.sda_s[1];
        n.trg_p = r.trg_s[1];

        // Which bus may carry commands
        if (i_interface_lock_field[sci_pkg::LOCK_FORCE]) begin
            spi_ok = !i_interface_lock_field[sci_pkg::LOCK_I2C];
            i2c_ok = i_interface_lock_field[sci_pkg::LOCK_I2C];
        end else begin
            spi_ok = !r.lk_set || !r.lk_i2c;
            i2c_ok = !r.lk_set || r.lk_i2c;
        end

        // SPI slave, mode 3: sample on rise, shift out on fall
        if (!cs) begin
            n.sda_drv = 1'b0;
            n.ist     = sci_pkg::I2_IDLE;
            if (r.cs_p) begin
                n.nbyte = 3'h0;
                n.done  = !spi_ok;
                n.sresp = 1'b0;
                n.sbit  = 3'h0;
            end else begin
                if (r.sck_s[1] && !r.sck_p) begin
                    n.ssh  = {r.ssh[6:0], r.sdi_s[1]};
                    n.sbit = r.sbit + 3'h1;
                    if (r.sbit == 3'h7) begin
                        bv   = 1'b1;
                        bdat = {r.ssh[6:0], r.sdi_s[1]};
                    end
                end
                if (!r.sck_s[1] && r.sck_p && r.sresp) begin
                    n.sdo = r.rsp[sci_pkg::RSP_W-1];
                    tx_sh = 1'b1;
                end
            end
        end else if (r.scl_s[1] && r.scl_p && r.sda_p && !r.sda_s[1]) begin
            // Start or repeated start
            n.ist     = sci_pkg::I2_ADDR;
            n.ibit    = 4'h0;
            n.sda_drv = 1'b0;
        end else if (r.scl_s[1] && r.scl_p && !r.sda_p && r.sda_s[1]) begin
            // Stop releases the line
            n.ist     = sci_pkg::I2_IDLE;
            n.sda_drv = 1'b0;
        end else if (r.scl_s[1] && !r.scl_p) begin
            // Clock rise: sample address or data, or master ack
            if (r.ist == sci_pkg::I2_ADDR || r.ist == sci_pkg::I2_WBYTE) begin
                n.ish  = {r.ish[6:0], r.sda_s[1]};
                n.ibit = r.ibit + 4'h1;
            end else if (r.ist == sci_pkg::I2_RACK && r.sda_s[1]) begin
                n.ist = sci_pkg::I2_IDLE;
            end
        end else if (!r.scl_s[1] && r.scl_p) begin
            // Clock fall: drive ack or next read bit
            unique case (r.ist)
                sci_pkg::I2_IDLE: begin
                end
                sci_pkg::I2_ADDR: begin
                    if (r.ibit == 4'h8) begin
                        if (r.ish[7:1] == P_I2C_ADDR && i2c_ok) begin
                            n.sda_drv = 1'b1;
                            n.irw     = r.ish[0];
                            n.ist     = sci_pkg::I2_AACK;
                            if (!r.ish[0]) begin
                                n.nbyte = 3'h0;
                                n.done  = 1'b0;
                            end
                        end else begin
                            n.ist = sci_pkg::I2_IDLE;
                        end
                    end
                end
                sci_pkg::I2_AACK: begin
                    n.ibit = 4'h0;
                    n.ist  = sci_pkg::I2_WBYTE;
                    n.sda_drv = 1'b0;
                    if (r.irw) begin
                        n.ist     = sci_pkg::I2_RBYTE;
                        n.sda_drv = !r.rsp[sci_pkg::RSP_W-1];
                        n.ibit    = 4'h1;
                        tx_sh     = 1'b1;
                    end
                end
                sci_pkg::I2_WBYTE: begin
                    if (r.ibit == 4'h8) begin
                        bv        = 1'b1;
                        bi2c      = 1'b1;
                        bdat      = r.ish;
                        n.sda_drv = 1'b1;
                        n.ist     = sci_pkg::I2_WACK;
                    end
                end
                sci_pkg::I2_WACK: begin
                    n.sda_drv = 1'b0;
                    n.ibit    = 4'h0;
                    n.ist     = sci_pkg::I2_WBYTE;
                end
                sci_pkg::I2_RBYTE: begin
                    if (r.ibit == 4'h8) begin
                        n.sda_drv = 1'b0;
                        n.ist     = sci_pkg::I2_RACK;
                    end else begin
                        n.sda_drv = !r.rsp[sci_pkg::RSP_W-1];
                        n.ibit    = r.ibit + 4'h1;
                        tx_sh     = 1'b1;
                    end
                end
                sci_pkg::I2_RACK: begin
                    n.ist     = sci_pkg::I2_RBYTE;
                    n.sda_drv = !r.rsp[sci_pkg::RSP_W-1];
                    n.ibit    = 4'h1;
                    tx_sh     = 1'b1;
                end
                default: begin
                    n.ist     = sci_pkg::I2_IDLE;
                    n.sda_drv = 1'b0;
                end
            endcase
        end

        // Byte assembly into a command
        first = (r.nbyte == 3'h0) ? bdat : r.op;
        argv  = {r.args[15:0], bdat};
        if (first[7:4] == sci_pkg::OP_RREAD) begin
            need = sci_pkg::LEN_RREAD;
        end else if (first[7:4] == sci_pkg::OP_RWRITE) begin
            need = sci_pkg::LEN_RWRITE;
        end else begin
            need = sci_pkg::LEN_ONE;
        end
        sel = (first[3:0] == 4'h0) ? i_burst_sel : first[3:0];
        if (bv && !r.done) begin
            if (r.nbyte == 3'h0) begin
                n.op = bdat;
            end else begin
                n.args = argv;
            end
            n.nbyte = r.nbyte + 3'h1;
            exec    = (r.nbyte + 3'h1) == need;
            n.done  = exec;
        end

        // Trigger pin and measurement completion
        if (r.single && i_single_done) begin
            n.single = 1'b0;
        end
        if (r.trg_s[1] && !r.trg_p && i_trig_en) begin
            n.single = 1'b1;
        end

        // Command execution
        if (exec) begin
            if (!r.lk_set) begin
                n.lk_set = 1'b1;
                n.lk_i2c = bi2c;
            end
            rej = i_ecc_double && first != sci_pkg::CMD_RESET;
            unique case (first[7:4])
                sci_pkg::OP_BURST:  expm = sci_pkg::MODE_BURST;
                sci_pkg::OP_WATCH:  expm = sci_pkg::MODE_WATCH;
                sci_pkg::OP_SINGLE: expm = sci_pkg::MODE_SINGLE;
                sci_pkg::OP_FETCH: begin
                    ferr = !i_result_ready_flag || sel == 4'h0;
                    n.taken = !rej;
                    // Pack selected results T, X, Y, Z
                    for (int i = 0; i < 4; i++) begin
                        if (sel[i]) begin
                            dat[63 - 16 * k -: 16] = mv[16 * i +: 16];
                            k = k + 3'h1;
                        end
                    end
                    dlen = 2'(k - 3'h1);
                end
                sci_pkg::OP_RREAD: begin
                    n.re   = !rej;
                    n.pend = !rej;
                    n.addr = argv[7:2];
                end
                sci_pkg::OP_RWRITE: begin
                    n.we    = !rej;
                    n.addr  = argv[7:2];
                    n.wdata = argv[23:8];
                end
                sci_pkg::OP_LEAVE: begin
                    rej = rej || first != sci_pkg::CMD_LEAVE;
                    if (!rej) begin
                        n.burst  = 1'b0;
                        n.watch  = 1'b0;
                        n.single = 1'b0;
                        n.leave  = 1'b1;
                    end
                end
                sci_pkg::OP_RECALL: begin
                    rej = rej || first != sci_pkg::CMD_RECALL || busy || r.single;
                    n.recall = !rej;
                end
                sci_pkg::OP_STORE: begin
                    rej = rej || first != sci_pkg::CMD_STORE || busy || r.single;
                    n.store = !rej;
                end
                sci_pkg::OP_RESET: begin
                    rt  = first == sci_pkg::CMD_RESET;
                    rej = !rt;
                end
                default: rej = 1'b1;
            endcase
            // Mode start, refused while an automatic mode runs
            if (expm != 3'h0) begin
                rej = rej || busy;
                if (!rej) begin
                    n.burst  = r.burst | expm[2];
                    n.watch  = r.watch | expm[1];
                    n.single = n.single | expm[0];
                    n.axis   = sel;
                    n.start  = 1'b1;
                end
            end
            // Status byte, rejected mode bit forced low
            modes = {n.burst, n.watch, n.single} & ~(rej ? expm : 3'h0);
            n.rsp = {modes, rej || ferr || i_ecc_double, i_corrected_bit_flag,
                     r.rs, dlen, dat};
            n.fresh = 1'b1;
            n.sresp = !bi2c;
            if (rt) begin
                n.burst  = 1'b0;
                n.watch  = 1'b0;
                n.single = 1'b0;
                n.lk_set = 1'b0;
                n.rs     = 1'b1;
                n.srst   = 1'b1;
                n.rsp    = '0;
                n.fresh  = 1'b0;
                n.sresp  = 1'b0;
            end
        end else begin
            modes = 3'h0;
        end

        // Register data is sampled in the cycle the read strobe is high
        if (r.pend) begin
            n.pend        = 1'b0;
            n.rsp[63:48]  = i_reg_rdata;
        end
        // Shift response; first status bit out clears reset-seen
        if (tx_sh) begin
            n.rsp = {n.rsp[sci_pkg::RSP_W-2:0], 1'b0};
            if (r.fresh) begin
                n.fresh = 1'b0;
                n.rs    = 1'b0;
            end
        end
    end

    // State register
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            r        <= '0;
            r.cs_s   <= 2'h3;
            r.sck_s  <= 2'h3;
            r.scl_s  <= 2'h3;
            r.sda_s  <= 2'h3;
            r.cs_p   <= 1'b1;
            r.sck_p  <= 1'b1;
            r.scl_p  <= 1'b1;
            r.sda_p  <= 1'b1;
            r.ist    <= sci_pkg::I2_IDLE;
            r.rs     <= 1'b1;
        end else begin
            r <= n;
        end
    end

    // Outputs
    assign o_sdo                      = r.sdo;
    assign o_sdo_oe_n                 = !(r.sresp && !r.cs_s[1]);
    assign o_sda_o                    = 1'b0;
    assign o_sda_oe_n                 = !r.sda_drv;
    assign o_burst_active             = r.burst;
    assign o_change_watch_active_flag = r.watch;
    assign o_single_active_flag       = r.single;
    assign o_reset_seen_flag          = r.rs;
    assign o_axis_sel                 = r.axis;
    assign o_start                    = r.start;
    assign o_leave                    = r.leave;
    assign o_nv_recall                = r.recall;
    assign o_nv_store                 = r.store;
    assign o_soft_reset               = r.srst;
    assign o_results_taken            = r.taken;
    assign o_reg_re                   = r.re;
    assign o_reg_we                   = r.we;
    assign o_reg_addr                 = r.addr;
    assign o_reg_wdata                = r.wdata;
endmodule

// File: sim/sci_spi_master.sv
// SPI master model: mode 3, half-duplex frames, one command per frame.
// Assumes the bench feeds i_miso from the device's data out and enable.
`timescale 1ns/10ps
module sci_spi_master (
    output logic      o_cs_n,
    output logic      o_sck,
    output logic      o_mosi,
    input  wire logic i_miso
);
    // Idle: deselected, clock high
    initial begin
        o_cs_n = 1'b1;
        o_sck = 1'b1;
        o_mosi = 1'b1;
    end
    // Frame of nt bytes out then nr bytes in; low phase long for sync lag
    task automatic xfer(input logic [31:0] tx, input int nt, input int nr,
                        output logic [71:0] rx);
        rx = '0;
        o_cs_n = 1'b0;
        #200;
        for (int i = 0; i < 8 * (nt + nr); i++) begin
            o_sck = 1'b0;
            o_mosi = (i < 8 * nt) ? tx[8 * nt - 1 - i] : ~o_mosi;
            #100 o_sck = 1'b1;
            if (i >= 8 * nt) begin
                rx = {rx[70:0], i_miso};
            end
            #60;
        end
        #200 o_cs_n = 1'b1;
        #600;
    endtask
endmodule

// File: sim/sci_cmd_if_assertions.sv
// Port checker for the command interface.
// Assumes binding to sci_cmd_if; sees only its ports.
`timescale 1ns/10ps
module sci_cmd_if_assertions (
    input wire logic       i_clk,
    input wire logic       i_sys_rst,
    input wire logic       i_protocol_select_n,
    input wire logic [1:0] i_interface_lock_field,
    input wire logic       i_trigger_pin,
    input wire logic       i_trig_en,
    input wire logic       i_single_done,
    input wire logic       o_sdo_oe_n,
    input wire logic       o_sda_oe_n,
    input wire logic       o_burst_active,
    input wire logic       o_change_watch_active_flag,
    input wire logic       o_single_active_flag,
    input wire logic       o_reset_seen_flag,
    input wire logic       o_start,
    input wire logic       o_leave,
    input wire logic       o_soft_reset
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);
    // Trigger rise, then single flag within sync delay
    sequence s_trig_rise;
        $rose(i_trigger_pin) && i_trig_en && !i_single_done;
    endsequence
    sequence s_single_up;
        ##[1:5] o_single_active_flag;
    endsequence
    a_reset_values: assert property (disable iff (1'b0) i_sys_rst |=>
        o_reset_seen_flag && o_sdo_oe_n && o_sda_oe_n && !o_start)
        else $error("outputs not at reset values");
    a_trig_single: assert property (s_trig_rise |-> s_single_up)
        else $error("trigger did not set single flag");
    a_start_mode: assert property (o_start |-> ##[0:1] (o_burst_active ||
        o_change_watch_active_flag || o_single_active_flag))
        else $error("start without active mode");
    a_start_pulse: assert property (o_start |=> !o_start)
        else $error("start pulse too long");
    a_leave_idle: assert property (o_leave |-> ##[0:1] !(o_burst_active ||
        o_change_watch_active_flag || o_single_active_flag))
        else $error("mode still active after leave");
    a_soft_rs: assert property (o_soft_reset |-> ##[0:1]
        (o_reset_seen_flag && !o_burst_active && !o_single_active_flag))
        else $error("soft reset did not clear state");
    a_oe_deselect: assert property (i_protocol_select_n [*6] |-> o_sdo_oe_n)
        else $error("data out driven while deselected");
    a_locked_quiet: assert property ((i_interface_lock_field == 2'h3) [*8] |->
        o_sdo_oe_n)
        else $error("data out driven on locked-out bus");
    a_rs_read: assert property ($fell(o_reset_seen_flag) |-> ##[0:2] !o_sdo_oe_n)
        else $error("reset flag cleared without status read");
endmodule
bind sci_cmd_if sci_cmd_if_assertions u_chk (
    .i_clk, .i_sys_rst, .i_protocol_select_n, .i_interface_lock_field, .i_trigger_pin,
    .i_trig_en, .i_single_done, .o_sdo_oe_n, .o_sda_oe_n, .o_burst_active,
    .o_change_watch_active_flag, .o_single_active_flag, .o_reset_seen_flag, .o_start,
    .o_leave, .o_soft_reset);

// File: sim/sci_cmd_if_tb_top.sv
// Self-checking bench: SPI command frames against the interpreter.
// Assumes the SPI master model and the bound port checker.
`timescale 1ns/10ps
module sci_cmd_if_tb_top;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        cs_n, sck, mosi, sdo, sdo_oe_n, single, rs;
    wire logic   miso;
    logic [1:0]  lock = 2'h0;
    logic [3:0]  bsel = 4'hA;
    logic        trigger_pin = 1'b0, trg_en = 1'b0, sdone = 1'b0, ready = 1'b1;
    logic        ecc = 1'b0, corr = 1'b0;
    logic [15:0] mt = 16'h1A2B, mx = 16'h3C4D, my = 16'h5E6F, mz = 16'h7081;
    logic [15:0] rdat = 16'hBEEF;
    logic [15:0] wdata;
    logic [5:0]  raddr;
    logic [3:0]  axis;
    logic        scl = 1'b1, sda_m = 1'b1, sda_oe_n;
    logic [8:0]  s;
    wire logic   sda;
    int          fail_count = 0;
    int          checks = 0;
    // Released data line shows the inverse of the last bit
    assign miso = sdo_oe_n ? ~sdo : sdo;
    // Two-wire data line with pull-up
    assign sda = sda_m & sda_oe_n;
    sci_cmd_if u_dut (
        .i_clk(clk), .i_sys_rst(rst), .i_protocol_select_n(cs_n), .i_sck(sck),
        .i_sdi(mosi), .o_sdo(sdo), .o_sdo_oe_n(sdo_oe_n), .i_scl(scl), .i_sda(sda),
        .o_sda_o(), .o_sda_oe_n(sda_oe_n), .i_interface_lock_field(lock), .i_burst_sel(bsel),
        .i_trigger_pin(trigger_pin), .i_trig_en(trg_en), .i_single_done(sdone),
        .i_result_ready_flag(ready), .i_ecc_double(ecc), .i_corrected_bit_flag(corr),
        .i_meas_t(mt), .i_meas_x(mx), .i_meas_y(my), .i_meas_z(mz),
        .i_reg_rdata(rdat), .o_burst_active(), .o_change_watch_active_flag(),
        .o_single_active_flag(single), .o_reset_seen_flag(rs), .o_axis_sel(axis),
        .o_start(), .o_leave(), .o_nv_recall(), .o_nv_store(), .o_soft_reset(),
        .o_results_taken(), .o_reg_re(), .o_reg_we(), .o_reg_addr(raddr),
        .o_reg_wdata(wdata));
    sci_spi_master u_mst (.o_cs_n(cs_n), .o_sck(sck), .o_mosi(mosi), .i_miso(miso));
    // System clock, 50 MHz
    initial begin
        forever #10 clk = ~clk;
    end
    // Compare and count
    task automatic chk(input string n, input logic [71:0] s, input logic [71:0] e);
        checks++;
        if (s !== e) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        end
    endtask
    // One command frame, response compared when bytes are read
    task automatic cmd(input logic [31:0] tx, input int nt, input int nr,
                       input logic [71:0] e);
        logic [71:0] rx;
        @(negedge clk);
        u_mst.xfer(tx, nt, nr, rx);
        if (nr > 0) begin
            chk("response", rx, e);
        end
    endtask
    // Two-wire bits MSB first; s keeps the line level while the clock is high
    task automatic i2c(input logic [8:0] b);
        for (int i = 8; i >= 0; i--) begin
            sda_m = b[i];
            #200 scl = 1'b1;
            #200 s[i] = sda;
            scl = 1'b0;
            #200;
        end
    endtask
    // Start (p low) or stop (p high): data moves while the clock is high
    task automatic i2c_se(input logic p);
        sda_m = !p;
        #200 scl = 1'b1;
        #200 sda_m = p;
        #200 scl = p;
    endtask
    // Verdict and end of run
    task automatic stop_test;
        $display("checks=%0d fail_count=%0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // Watchdog
    initial begin
        #400000;
        fail_count++;
        stop_test();
    end
    // Command sequence
    initial begin
        repeat (20) @(posedge clk);
        @(negedge clk) rst = 1'b0;
        repeat (5) @(negedge clk);
        cmd(32'h16, 1, 1, 72'h84);
        chk("axis", 72'(axis), 72'h6);
        cmd(32'h35, 1, 1, 72'h90);
        @(negedge clk) corr = 1'b1;
        cmd(32'h80, 1, 1, 72'h08);
        @(negedge clk) corr = 1'b0;
        cmd(32'h20, 1, 1, 72'h40);
        chk("axis", 72'(axis), 72'hA);
        cmd(32'h80, 1, 1, 72'h00);
        cmd(32'h70, 1, 1, 72'h10);
        cmd(32'h45, 1, 5, 72'h011A2B5E6F);
        @(negedge clk) ready = 1'b0;
        cmd(32'h41, 1, 3, 72'h101A2B);
        cmd(32'h5048, 2, 3, 72'h00BEEF);
        chk("raddr", 72'(raddr), 72'h12);
        cmd(32'h60A55A48, 4, 1, 72'h00);
        chk("wdata", 72'(wdata), 72'hA55A);
        @(negedge clk) lock = 2'h3;
        cmd(32'h11, 1, 0, 72'h0);
        @(negedge clk) lock = 2'h2;
        cmd(32'h31, 1, 1, 72'h20);
        @(negedge clk) sdone = 1'b1;
        @(negedge clk) sdone = 1'b0;
        chk("single", 72'(single), 72'h0);
        trg_en = 1'b1;
        @(negedge clk) trigger_pin = 1'b1;
        repeat (8) @(negedge clk);
        chk("single", 72'(single), 72'h1);
        trigger_pin = 1'b0;
        @(negedge clk) sdone = 1'b1;
        @(negedge clk) sdone = 1'b0;
        ecc = 1'b1;
        cmd(32'h11, 1, 1, 72'h10);
        @(negedge clk) ecc = 1'b0;
        cmd(32'hF0, 1, 0, 72'h0);
        chk("rs", 72'(rs), 72'h1);
        cmd(32'h80, 1, 1, 72'h04);
        chk("rs", 72'(rs), 72'h0);
        // Two-wire: invalid command acknowledged, status read back
        @(negedge clk) lock = 2'h3;
        i2c_se(1'b0);
        i2c(9'h031);
        chk("addr_ack", 72'(s[0]), 72'h0);
        i2c(9'h0E1);
        chk("cmd_ack", 72'(s[0]), 72'h0);
        i2c_se(1'b1);
        i2c_se(1'b0);
        i2c(9'h033);
        i2c(9'h1FF);
        chk("i2c_status", 72'(s[8:1]), 72'h10);
        i2c_se(1'b1);
        @(negedge clk) lock = 2'h2;
        cmd(32'hD0, 1, 1, 72'h00);
        cmd(32'hE0, 1, 1, 72'h00);
        stop_test();
    end
endmodule
